//--- rtl/cam_step_pkg.sv
// constants, register map and carriers for the cam step sequencer
// assumes a 32-bit classic wishbone slave port and a 40 MHz clock
package cam_step_pkg;

  // ==========================================================
  // geometry
  localparam int unsigned TRACKS    = 8;
  localparam int unsigned MAX_STEPS = 50;
  localparam int unsigned POS_W     = 6;
  localparam int unsigned ADR_W     = 10;

  localparam logic [POS_W-1:0] POS_ZERO  = 6'h00;
  localparam logic [POS_W-1:0] POS_ONE   = 6'h01;
  localparam logic [POS_W-1:0] STEPS_MIN = 6'h01;
  localparam logic [POS_W-1:0] STEPS_MAX = 6'h32;

  // ==========================================================
  // register byte addresses
  localparam logic [ADR_W-1:0] CTRL_ADR   = 10'h000;
  localparam logic [ADR_W-1:0] STATUS_ADR = 10'h004;
  localparam logic [ADR_W-1:0] FLAGS_ADR  = 10'h008;
  localparam logic [ADR_W-1:0] TABLE_ADR  = 10'h100;

  // ==========================================================
  // field positions
  localparam int unsigned CTRL_STEPS_LSB  = 0;
  localparam int unsigned CTRL_RETAIN_BIT = 8;
  localparam int unsigned STAT_POS_LSB    = 0;
  localparam int unsigned STAT_TRACK_LSB  = 8;
  localparam int unsigned STAT_HOLD_BIT   = 16;
  localparam int unsigned FLAG_WRAP_FWD   = 0;
  localparam int unsigned FLAG_WRAP_BWD   = 1;
  localparam int unsigned FLAG_RESTORE    = 2;

  // ==========================================================
  // reset values
  localparam logic [POS_W-1:0]  STEPS_RESET  = 6'h32;
  localparam logic              RETAIN_RESET = 1'b0;
  localparam logic [TRACKS-1:0] TRACK_RESET  = 8'h00;
  localparam logic [31:0]       WORD_ZERO    = 32'h0000_0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [POS_W-1:0] steps;
    logic             retain;
  } ctrl_s;

  typedef struct packed {
    logic advance;
    logic retreat;
    logic hold;
    logic restore;
  } step_in_s;

  typedef enum logic [1:0] {
    MOVE_NONE    = 2'b00,
    MOVE_ADVANCE = 2'b01,
    MOVE_RETREAT = 2'b10,
    MOVE_HOLD    = 2'b11
  } move_e;

endpackage

//--- rtl/cam_step_sequencer.sv
// cam programmer: eight cam tracks driven by a stepping position counter
// assumes step pins are asynchronous to clk_i; registers over wishbone
//
// Operation
// [RULE_01] each advance rising edge moves the position one step forward
// [RULE_02] each retreat rising edge moves the position one step back
// [RULE_03] while reset input is active the position is held at zero
// [RULE_04] eight track outputs follow the table entry of current position
// [RULE_05] position output shows the current position, zero to forty-nine
// [RULE_06] step count is configurable from one to fifty
// [RULE_07] table holds on/off state of each track at each position
// [RULE_08] stepping past the last configured step restarts at zero
// [RULE_09] simultaneous advance and retreat edges act on advance only
// [RULE_10] an unconnected advance or retreat input counts as inactive
// [RULE_11] power restore keeps position if retention set, else zero
// [RULE_12] retreat at zero wraps to step count minus one
// [RULE_13] reset input wins over any simultaneous step edge
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module cam_step_sequencer (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // wishbone classic slave
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [cam_step_pkg::ADR_W-1:0] adr_i,
  input  wire logic [3:0]                     sel_i,
  input  wire logic [31:0]                    dat_i,
  output logic      [31:0]                    dat_o,
  output logic                                ack_o,
  // step pins
  input  wire logic                           advance_i,
  input  wire logic                           retreat_i,
  input  wire logic                           advance_conn_i,
  input  wire logic                           retreat_conn_i,
  input  wire logic                           cam_reset_i,
  input  wire logic                           power_restore_i,
  // results
  output logic [cam_step_pkg::TRACKS-1:0]     track_out_o,
  output logic [cam_step_pkg::POS_W-1:0]      position_o
);
  import cam_step_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [POS_W-1:0] last_step(
    input logic [POS_W-1:0] steps
  );
    last_step = steps - POS_ONE;
  endfunction

  // exact match on one register word
  function automatic logic reg_hit(
    input logic [ADR_W-1:0] adr,
    input logic [ADR_W-1:0] base
  );
    reg_hit = (adr == base);
  endfunction

  // a table window hit; returns the entry index through idx
  function automatic logic table_hit(
    input  logic [ADR_W-1:0] adr,
    output logic [POS_W-1:0] idx
  );
    logic [ADR_W-1:0] off;
    off = adr - TABLE_ADR;
    idx = off[POS_W+1:2];
    table_hit = (adr >= TABLE_ADR) && (off[1:0] == 2'b00)
      && (off[ADR_W-1:POS_W+2] == '0) && (idx < STEPS_MAX);
  endfunction

  // clamp written step counts into the legal range
  function automatic logic [POS_W-1:0] clamp_steps(
    input logic [POS_W-1:0] v
  );
    if (v < STEPS_MIN) begin
      clamp_steps = STEPS_MIN;
    end else if (v > STEPS_MAX) begin
      clamp_steps = STEPS_MAX;
    end else begin
      clamp_steps = v;
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  step_in_s sync_a;
  step_in_s sync_b;
  logic     adv_conn_a;
  logic     adv_conn_b;
  logic     ret_conn_a;
  logic     ret_conn_b;

  // step and level pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= '{advance_i, retreat_i, cam_reset_i,
                  power_restore_i};
      sync_b <= sync_a;
    end
  end

  // connection straps, a slow level like the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_conn_a <= 1'b0;
      adv_conn_b <= 1'b0;
      ret_conn_a <= 1'b0;
      ret_conn_b <= 1'b0;
    end else begin
      adv_conn_a <= advance_conn_i;
      adv_conn_b <= adv_conn_a;
      ret_conn_a <= retreat_conn_i;
      ret_conn_b <= ret_conn_a;
    end
  end

  // loose inputs read as low, so no edge can come from them
  logic adv_level;
  logic adv_level_q;
  logic ret_level;
  logic ret_level_q;
  logic restore_q;
  logic adv_edge;
  logic ret_edge;
  logic restore_edge;

  always_comb begin
    adv_level = sync_b.advance & adv_conn_b;  // RULE_10
    ret_level = sync_b.retreat & ret_conn_b;  // RULE_10
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_level_q <= 1'b0;
      ret_level_q <= 1'b0;
      restore_q   <= 1'b0;
    end else begin
      adv_level_q <= adv_level;
      ret_level_q <= ret_level;
      restore_q   <= sync_b.restore;
    end
  end

  always_comb begin
    adv_edge     = adv_level & ~adv_level_q;  // RULE_01
    ret_edge     = ret_level & ~ret_level_q;  // RULE_02
    restore_edge = sync_b.restore & ~restore_q;
  end

  // ==========================================================
  // configuration
  ctrl_s            ctrl;
  logic [TRACKS-1:0] cam_table [MAX_STEPS];
  logic             bus_req;
  logic             bus_wr;
  logic [POS_W-1:0] wr_idx;
  logic             wr_table;

  always_comb begin
    bus_req  = cyc_i & stb_i & ~ack_o;
    bus_wr   = bus_req & we_i;
    wr_table = table_hit(adr_i, wr_idx) & bus_wr & sel_i[0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl.steps  <= STEPS_RESET;
      ctrl.retain <= RETAIN_RESET;
    end else if (bus_wr && reg_hit(adr_i, CTRL_ADR)) begin
      if (sel_i[0]) begin
        ctrl.steps <= clamp_steps(
          dat_i[CTRL_STEPS_LSB +: POS_W]);  // RULE_06
      end
      if (sel_i[1]) begin
        ctrl.retain <= dat_i[CTRL_RETAIN_BIT];
      end
    end
  end

  // table contents survive rst_i like a parameter memory
  always_ff @(posedge clk_i) begin
    if (wr_table) begin
      cam_table[wr_idx] <= dat_i[TRACKS-1:0];  // RULE_07
    end
  end

  // ==========================================================
  // position counter
  move_e            move;
  logic [POS_W-1:0] pos;
  logic [POS_W-1:0] next_pos;
  logic [POS_W-1:0] top;
  logic             wrap_fwd;
  logic             wrap_bwd;

  always_comb begin
    top = last_step(ctrl.steps);
    if (sync_b.hold) begin
      move = MOVE_HOLD;  // RULE_13
    end else if (adv_edge) begin
      move = MOVE_ADVANCE;  // RULE_09
    end else if (ret_edge) begin
      move = MOVE_RETREAT;
    end else begin
      move = MOVE_NONE;
    end
  end

  always_comb begin
    next_pos = pos;
    wrap_fwd = 1'b0;
    wrap_bwd = 1'b0;
    case (move)
      MOVE_HOLD: begin
        next_pos = POS_ZERO;  // RULE_03
      end
      MOVE_ADVANCE: begin
        // a shrunk step count may leave pos above top
        if (pos >= top) begin
          next_pos = POS_ZERO;  // RULE_08
          wrap_fwd = 1'b1;
        end else begin
          next_pos = pos + POS_ONE;  // RULE_01
        end
      end
      MOVE_RETREAT: begin
        if (pos == POS_ZERO) begin
          next_pos = top;  // RULE_12
          wrap_bwd = 1'b1;
        end else if (pos > top) begin
          next_pos = top;
        end else begin
          next_pos = pos - POS_ONE;  // RULE_02
        end
      end
      default: begin
        next_pos = pos;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos <= POS_ZERO;
    end else if (restore_edge && move != MOVE_HOLD) begin
      // a restore without retention restarts the cam
      pos <= ctrl.retain ? next_pos : POS_ZERO;  // RULE_11
    end else begin
      pos <= next_pos;
    end
  end

  // ==========================================================
  // outputs, one cycle behind the position
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      position_o <= POS_ZERO;
    end else begin
      position_o <= pos;  // RULE_05
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      track_out_o <= TRACK_RESET;
    end else begin
      track_out_o <= cam_table[pos];  // RULE_04
    end
  end

  // ==========================================================
  // sticky event flags, write one to clear, set wins
  localparam int unsigned FLAG_CNT = FLAG_RESTORE + 1;
  logic [FLAG_CNT-1:0] flags;
  logic [FLAG_CNT-1:0] flag_set;
  logic [FLAG_CNT-1:0] flag_clr;

  always_comb begin
    flag_set = '0;
    flag_set[FLAG_WRAP_FWD] = wrap_fwd;
    flag_set[FLAG_WRAP_BWD] = wrap_bwd;
    flag_set[FLAG_RESTORE]  = restore_edge;
    flag_clr = '0;
    if (bus_wr && reg_hit(adr_i, FLAGS_ADR) && sel_i[0]) begin
      flag_clr = dat_i[FLAG_CNT-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // ==========================================================
  // bus read path and acknowledge
  logic [31:0]      next_dat;
  logic [POS_W-1:0] rd_idx;
  logic             rd_table;

  always_comb begin
    next_dat = WORD_ZERO;
    rd_table = table_hit(adr_i, rd_idx);
    if (reg_hit(adr_i, CTRL_ADR)) begin
      next_dat[CTRL_STEPS_LSB +: POS_W] = ctrl.steps;
      next_dat[CTRL_RETAIN_BIT]         = ctrl.retain;
    end else if (reg_hit(adr_i, STATUS_ADR)) begin
      next_dat[STAT_POS_LSB +: POS_W]    = pos;
      next_dat[STAT_TRACK_LSB +: TRACKS] = track_out_o;
      next_dat[STAT_HOLD_BIT]            = sync_b.hold;
    end else if (reg_hit(adr_i, FLAGS_ADR)) begin
      next_dat[FLAG_CNT-1:0] = flags;
    end else if (rd_table) begin
      next_dat[TRACKS-1:0] = cam_table[rd_idx];
    end
  end

  // unmapped addresses still ack and read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  // read data stands only while ack does
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= WORD_ZERO;
    end else begin
      dat_o <= (bus_req && !we_i) ? next_dat : WORD_ZERO;
    end
  end

endmodule

`default_nettype wire

//--- tb/cam_step_pins.sv
// far side: controller logic making step pulses on the two step pins
// assumes the caller enters step right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module cam_step_pins (
  input  wire logic clk_i,
  output logic      advance_o,
  output logic      retreat_o
);
  // ========
  // step pulses
  initial begin
    advance_o = 1'b0;
    retreat_o = 1'b0;
  end
  // long low gap so the next rising edge is never merged
  task automatic step(input logic fwd, input logic bwd);
    @(posedge clk_i);
    advance_o <= fwd;
    retreat_o <= bwd;
    repeat (5) @(posedge clk_i);
    advance_o <= 1'b0;
    retreat_o <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- tb/cam_step_sequencer_bench.sv
// bench: register and step pin tests of the cam sequencer
// assumes cam_step_pins drives the step pins from the far side
`timescale 1ns/1ps
`default_nettype none
module cam_step_sequencer_bench;
  import cam_step_pkg::*;
  // ========
  // stimulus and wiring
  logic              clk_i;
  logic              rst_i;
  logic              cyc, stb, we, conn, cam_rst, restore, ack_o, adv, ret;
  logic [ADR_W-1:0]  adr;
  logic [31:0]       wdat, dat_o, q;
  logic [TRACKS-1:0] track_out_o;
  logic [POS_W-1:0]  position_o;
  int                err_total, comparisons, cycles;

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  cam_step_pins cam_step_pins_inst (.clk_i(clk_i), .advance_o(adv),
    .retreat_o(ret));
  cam_step_sequencer cam_step_sequencer_inst (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .advance_i(adv), .retreat_i(ret), .advance_conn_i(conn),
    .retreat_conn_i(conn), .cam_reset_i(cam_rst),
    .power_restore_i(restore), .track_out_o(track_out_o),
    .position_o(position_o));

  // ========
  // tasks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [ADR_W-1:0] a,
                    input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(n, e, q);
  endtask
  function automatic logic [7:0] pat(input int i);
    return 8'(i) ^ 8'h5a;
  endfunction
  task automatic at(input logic [POS_W-1:0] p);
    chk("position", 32'(p), 32'(position_o));
    chk("tracks", 32'(pat(int'(p))), 32'(track_out_o));
  endtask
  task automatic bump();
    restore <= 1'b1;
    repeat (4) @(posedge clk_i);
    restore <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic mv(input logic f, input logic b);
    cam_step_pins_inst.step(f, b);
  endtask

  // ========
  // tests
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, cam_rst, restore} = 5'h00;
    conn = 1'b1;
    adr = 10'h000;
    wdat = 32'h0000_0000;
    {err_total, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl", CTRL_ADR, 32'h0000_0032);
    rd("unmapped", 10'h0c0, 32'h0000_0000);
    chk("position", 32'(POS_ZERO), 32'(position_o));
    for (int i = 0; i < 50; i++) begin
      wb(1'b1, TABLE_ADR + ADR_W'(4 * i), 32'(pat(i)));
    end
    at(POS_ZERO);
    rd("table", TABLE_ADR + 10'h0c4, 32'(pat(49)));
    $display("test reset done");
    wb(1'b1, CTRL_ADR, 32'h0000_0003);
    for (int i = 1; i < 4; i++) begin
      mv(1'b1, 1'b0);
      at(POS_W'(i % 3));
    end
    rd("flags", FLAGS_ADR, 32'h0000_0001);
    $display("test forward done");
    mv(1'b0, 1'b1);
    at(6'h02);
    mv(1'b0, 1'b1);
    at(POS_ONE);
    mv(1'b1, 1'b1);
    at(6'h02);
    rd("flags", FLAGS_ADR, 32'h0000_0003);
    wb(1'b1, FLAGS_ADR, 32'h0000_0003);
    rd("flags", FLAGS_ADR, 32'h0000_0000);
    $display("test reverse done");
    conn <= 1'b0;
    mv(1'b1, 1'b0);
    at(6'h02);
    conn <= 1'b1;
    cam_rst <= 1'b1;
    mv(1'b1, 1'b0);
    at(POS_ZERO);
    rd("status", STATUS_ADR, 32'h0001_5a00);
    cam_rst <= 1'b0;
    $display("test pins done");
    mv(1'b1, 1'b0);
    bump();
    at(POS_ZERO);
    rd("flags", FLAGS_ADR, 32'h0000_0004);
    wb(1'b1, CTRL_ADR, 32'h0000_0103);
    mv(1'b1, 1'b0);
    bump();
    at(POS_ONE);
    $display("test retain done");
    wb(1'b1, CTRL_ADR, 32'h0000_0032);
    mv(1'b0, 1'b1);
    mv(1'b0, 1'b1);
    at(6'h31);
    rd("status", STATUS_ADR, 32'h0000_6b31);
    wb(1'b1, CTRL_ADR, 32'h0000_0000);
    rd("ctrl", CTRL_ADR, 32'h0000_0001);
    wb(1'b1, CTRL_ADR, 32'h0000_003f);
    rd("ctrl", CTRL_ADR, 32'h0000_0032);
    $display("test limits done");
    wrap_up();
  end
endmodule
`default_nettype wire

//--- tb/cam_step_sequencer_chk.sv
// checker: port-level properties of the cam step sequencer
// assumes binding to cam_step_sequencer; steps register unseen
`timescale 1ns/1ps
`default_nettype none
module cam_step_sequencer_chk
  import cam_step_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             ack_o,
  input wire logic             advance_i,
  input wire logic             retreat_i,
  input wire logic             advance_conn_i,
  input wire logic             retreat_conn_i,
  input wire logic             cam_reset_i,
  input wire logic             power_restore_i,
  input wire logic [POS_W-1:0] position_o
);
  // ========
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic calm;
  // wrap allowed as the step count is not visible here
  assign calm = !cam_reset_i && !power_restore_i && advance_conn_i
    && retreat_conn_i;
  AST_FWD: assert property (
    (!advance_i && !retreat_i && calm)[*4] ##1
    (advance_i && !retreat_i && calm)[*5] |=>
    position_o == $past(position_o, 5) + 6'h01 || position_o == 6'h00)
    else $error("advance step wrong");
  AST_BWD: assert property (
    (!advance_i && !retreat_i && calm)[*4] ##1
    (!advance_i && retreat_i && calm)[*5] |=>
    position_o == $past(position_o, 5) - 6'h01
    || $past(position_o, 5) == 6'h00)
    else $error("retreat step wrong");
  AST_PRIO: assert property (
    (!advance_i && !retreat_i && calm)[*4] ##1
    (advance_i && retreat_i && calm)[*5] |=>
    position_o == $past(position_o, 5) + 6'h01 || position_o == 6'h00)
    else $error("joint edges not forward");
  AST_UNCONN: assert property (
    (!advance_conn_i && !retreat_conn_i && !cam_reset_i
    && !power_restore_i)[*6] |=> $stable(position_o))
    else $error("unconnected pin moved cam");
  AST_CAMRST: assert property (
    cam_reset_i[*4] |=> position_o == 6'h00)
    else $error("cam reset not zero");
  AST_RANGE: assert property (
    position_o <= 6'h31)
    else $error("position out of range");
  AST_ACK_REQ: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
endmodule

bind cam_step_sequencer cam_step_sequencer_chk cam_step_sequencer_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .advance_i(advance_i), .retreat_i(retreat_i),
  .advance_conn_i(advance_conn_i), .retreat_conn_i(retreat_conn_i),
  .cam_reset_i(cam_reset_i), .power_restore_i(power_restore_i),
  .position_o(position_o));
`default_nettype wire
